// *** hw/sp_compand_map.svh ***
// Register map, field positions and counts for the serial port compander.
`ifndef SP_COMPAND_MAP_SVH
`define SP_COMPAND_MAP_SVH
`define A_CTRL   8'h00
`define A_CFG    8'h04
`define A_TXD    8'h08
`define A_RXD    8'h0C
`define A_STAT   8'h10
`define C_RXEN   0
`define C_TXEN   1
`define C_LOOP   2
`define C_FRAME_GEN_RESET_N   3
`define C_FMODE  4
`define C_JUST   6:5
`define G_TXLAW  1:0
`define G_RXLAW  3:2
`define G_TXLEN  6:4
`define G_RXLEN  9:7
`define G_TXCI   10
`define G_TXFI   11
`define G_RXCI   12
`define G_RXFI   13
`define J_ZERO   2'h0
`define J_SIGN   2'h1
`define J_HIGH   2'h2
`define RESP_OK  2'h0
`define RESP_ERR 2'h2
`define LOOP_CYC 3'h4
`define SRG_DIV  4'h4
`define SRG_HALF 4'h2
`define FSG_PER  6'h28
`define MU_CLIP  14'h1FDE
`define MU_BIAS  14'h0021
`define A_CLIP   12'hFFF
`endif

// *** hw/sp_compand_pkg.sv ***
// Types shared by the serial port compander files.
package sp_compand_pkg;
  typedef enum logic [1:0] {LAW_NONE, LAW_LSB, LAW_MU, LAW_A} law_e;
  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_e;
  typedef enum logic {RX_IDLE, RX_SHIFT} rx_state_e;
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_s;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_s;
  typedef struct packed {
    logic tx_bit_clock_i;
    logic tx_frame_sync_i;
    logic rx_bit_clock_i;
    logic rx_frame_sync_i;
    logic rx_data_i;
  } pin_in_s;
  typedef struct packed {
    logic tx_bit_clock_o, tx_bit_clock_oe;
    logic tx_frame_sync_o, tx_frame_sync_oe;
    logic rx_bit_clock_o, rx_bit_clock_oe;
    logic rx_frame_sync_o, rx_frame_sync_oe;
    logic tx_data_o, tx_data_oe;
  } pin_out_s;
endpackage : sp_compand_pkg

// *** hw/sp_compand_codec.sv ***
// Mu-law and A-law compressor, expander and byte reversal.
`timescale 1ns/10ps
`include "sp_compand_map.svh"
module sp_compand_codec (
  input  wire logic [15:0]          tx_word,
  input  wire sp_compand_pkg::law_e tx_law,
  input  wire logic                 tx_rev,
  output logic [7:0]                tx_byte,
  input  wire logic [15:0]          rx_word,
  input  wire sp_compand_pkg::law_e rx_law,
  input  wire logic                 rx_rev,
  output logic [15:0]               rx_lin
);
  import sp_compand_pkg::*;

  logic [7:0] tx_flip;
  logic [7:0] rx_flip;

  // bit order reversal
  // A streaming operator cannot sit inside a select or a concatenation, so wire it per bit.
  for (genvar b = 0; b < 8; b++) begin : g_rev
    assign tx_flip[b] = tx_word[7-b];
    assign rx_flip[b] = rx_word[7-b];
  end

  function automatic logic [7:0] mu_enc(input logic [15:0] l);
    logic [13:0] x, m;
    logic [2:0]  sg;
    x = l[15:2];
    m = x[13] ? 14'(-x) : x;
    if (m > `MU_CLIP) m = `MU_CLIP;
    m  = m + `MU_BIAS;
    sg = 3'h0;
    for (int i = 6; i <= 12; i++) if (m[i]) sg = 3'(i - 5);
    return {1'b0, sg, 4'(m >> (sg + 3'h1))} ^ (x[13] ? 8'h7F : 8'hFF);
  endfunction : mu_enc

  function automatic logic [7:0] a_enc(input logic [15:0] l);
    logic [12:0] x, n;
    logic [11:0] m;
    logic [2:0]  sg;
    x = l[15:3];
    n = x[12] ? 13'(-x) : x;
    m  = n[12] ? `A_CLIP : n[11:0];
    sg = 3'h0;
    for (int i = 5; i <= 11; i++) if (m[i]) sg = 3'(i - 4);
    return {~x[12], sg, 4'(m >> ((sg == 3'h0) ? 3'h1 : sg))} ^ 8'h55;
  endfunction : a_enc

  function automatic logic [15:0] mu_dec(input logic [7:0] k);
    logic [7:0]  c;
    logic [15:0] t;
    c = ~k;
    t = ({9'h0, c[3:0], 3'h0} + 16'h0084) << c[6:4];
    return c[7] ? 16'(16'h0084 - t) : 16'(t - 16'h0084);
  endfunction : mu_dec

  function automatic logic [15:0] a_dec(input logic [7:0] k);
    logic [7:0]  c;
    logic [15:0] t;
    c = k ^ 8'h55;
    t = {8'h0, c[3:0], 4'h0};
    if (c[6:4] == 3'h0) t = t + 16'h0008;
    else t = (t + 16'h0108) << (c[6:4] - 3'h1);
    return c[7] ? t : 16'(-t);
  endfunction : a_dec

  always_comb begin
    case (tx_law)
      LAW_MU:  tx_byte = mu_enc(tx_word);
      LAW_A:   tx_byte = a_enc(tx_word);
      default: tx_byte = tx_rev ? tx_flip : tx_word[7:0];
    endcase
    case (rx_law)
      LAW_MU:  rx_lin = mu_dec(rx_word[7:0]);
      LAW_A:   rx_lin = a_dec(rx_word[7:0]);
      default: rx_lin = rx_rev ? {8'h00, rx_flip} : rx_word;
    endcase
  end
endmodule : sp_compand_codec

// *** hw/sp_compand_port.sv ***
// Serial port companding stage with register slave and shared generators.
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`include "sp_compand_map.svh"
module sp_compand_port (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire sp_compand_pkg::axi_req_s axi_req,
  output sp_compand_pkg::axi_rsp_s      axi_rsp,
  input  wire sp_compand_pkg::pin_in_s  pins_in,
  output sp_compand_pkg::pin_out_s      pins_out,
  output logic                          rx_sync_event,
  output logic                          tx_sync_event
);
  import sp_compand_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        aw_ok;
    logic [7:0]  aw_addr;
    logic        w_ok;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [6:0]  ctrl;
    logic [13:0] cfg;
    logic [31:0] tx_data_reg;
    logic        dxr_full;
    logic [15:0] tx_shift_reg;
    tx_state_e   tx_st;
    logic [4:0]  tx_cnt;
    logic        fs_o;
    logic        dx;
    logic [15:0] rsr;
    logic [15:0] rx_buffer_reg;
    logic        rbr_new;
    rx_state_e   rx_st;
    logic [4:0]  rx_cnt;
    logic [31:0] rx_data_reg;
    logic        rx_rdy;
    logic        rx_fs_o;
    logic [2:0]  lp_cnt;
    logic [7:0]  lp_code;
    logic [3:0]  srg_cnt;
    logic        clkg;
    logic [5:0]  fsg_cnt;
    logic [4:0]  s1;
    logic [4:0]  s2;
    logic [1:0]  clk_prev;
    logic        tx_evt;
    logic        rx_evt;
  } st_s;

  st_s  q;
  st_s  d;
  logic tx_en, rx_en, loop_on, frame_gen_reset_n, fmode;
  logic txci, txfi, rxci, rxfi;
  law_e tx_law, rx_law;
  logic tx_el8, rx_el8, tx_rev, rx_rev, rx_comp;
  logic clkg_tick, fsg_pulse, tx_tick, rx_tick;
  logic tx_fs_src, fs_copy_mode, tx_start, rx_fs, rx_din, rx_copy;
  logic tx_rdy, srg_used, fsg_used;
  logic wr_fire, rd_fire, wr_bad, rd_bad;
  logic [7:0]  tx_byte;
  logic [15:0] rx_lin, rx_word;
  logic [31:0] rx_just;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  // Control and configuration fields steer every path below.
  assign tx_en   = q.ctrl[`C_TXEN];
  assign rx_en   = q.ctrl[`C_RXEN];
  assign loop_on = q.ctrl[`C_LOOP];
  assign frame_gen_reset_n    = q.ctrl[`C_FRAME_GEN_RESET_N];
  assign fmode   = q.ctrl[`C_FMODE];
  assign txci    = q.cfg[`G_TXCI];
  assign txfi    = q.cfg[`G_TXFI];
  assign rxci    = q.cfg[`G_RXCI];
  assign rxfi    = q.cfg[`G_RXFI];
  assign tx_law  = law_e'(q.cfg[`G_TXLAW]);
  assign rx_law  = law_e'(q.cfg[`G_RXLAW]);
  assign rx_comp = q.cfg[3];
  assign tx_el8  = q.cfg[1] || (q.cfg[`G_TXLEN] == 3'h0);
  assign rx_el8  = rx_comp || (q.cfg[`G_RXLEN] == 3'h0);
  assign tx_rev  = (tx_law == LAW_LSB) && (q.cfg[`G_TXLEN] == 3'h0);
  assign rx_rev  = (rx_law == LAW_LSB) && (q.cfg[`G_RXLEN] == 3'h0);

  // ----------------------------------------------------------------
  // Shared generators and source selection
  // ----------------------------------------------------------------
  // shared generators
  assign clkg_tick = (q.srg_cnt == `SRG_DIV - 4'h1);
  assign fsg_pulse = clkg_tick && frame_gen_reset_n && (q.fsg_cnt == 6'h00);
  // Pin edges are taken only from the second synchroniser stage.
  assign tx_tick = txci ? clkg_tick : (q.s2[4] && !q.clk_prev[1]);
  assign rx_tick = loop_on ? tx_tick :
                   rxci ? clkg_tick : (q.s2[2] && !q.clk_prev[0]);
  assign fs_copy_mode = txfi && !fmode;
  assign tx_fs_src    = txfi ? fsg_pulse : q.s2[3];
  assign tx_start = tx_en && tx_tick && (q.tx_st == TX_IDLE) &&
                    (fs_copy_mode ? q.dxr_full : tx_fs_src);
  assign rx_fs  = loop_on ? tx_start : rxfi ? fsg_pulse : q.s2[1];
  assign rx_din = loop_on ? q.dx : q.s2[0];
  assign rx_copy = q.rbr_new && rx_en;
  assign tx_rdy   = tx_en && !q.dxr_full;
  assign srg_used = (tx_en && txci) || (rx_en && rxci && !loop_on);
  assign fsg_used = frame_gen_reset_n && ((tx_en && txfi && fmode) || (rx_en && rxfi));

  assign rx_word = (q.lp_cnt != 3'h0) ? {8'h00, q.lp_code} : q.rx_buffer_reg;

  sp_compand_codec codec (
    .tx_word (q.tx_data_reg[15:0]),
    .tx_law  (tx_law),
    .tx_rev  (tx_rev),
    .tx_byte (tx_byte),
    .rx_word (rx_word),
    .rx_law  (rx_law),
    .rx_rev  (rx_rev),
    .rx_lin  (rx_lin)
  );

  always_comb begin
    if (!rx_comp) rx_just = {16'h0000, rx_lin};
    else if (q.ctrl[`C_JUST] == `J_SIGN) rx_just = {{16{rx_lin[15]}}, rx_lin};
    else if (q.ctrl[`C_JUST] == `J_HIGH) rx_just = {rx_lin, 16'h0000};
    else rx_just = {16'h0000, rx_lin};
  end

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  assign wr_fire = q.aw_ok && q.w_ok && !q.bvalid;
  assign rd_fire = axi_req.arvalid && !q.rvalid;
  assign wr_bad  = (q.aw_addr > `A_STAT) || (q.aw_addr[1:0] != 2'h0);
  assign rd_bad  = (axi_req.araddr > `A_STAT) || (axi_req.araddr[1:0] != 2'h0);
  always_comb begin
    axi_rsp.awready = !q.aw_ok;
    axi_rsp.wready  = !q.w_ok;
    axi_rsp.bvalid  = q.bvalid;
    axi_rsp.bresp   = q.bresp;
    axi_rsp.arready = !q.rvalid;
    axi_rsp.rvalid  = q.rvalid;
    axi_rsp.rdata   = q.rdata;
    axi_rsp.rresp   = q.rresp;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // One combinational pass builds the whole next state.
  always_comb begin
    logic [31:0] wm;
    logic [15:0] ld;
    wm = 32'h0;
    ld = 16'h0;
    d  = q;
    d.tx_evt = 1'b0;
    d.rx_evt = 1'b0;
    d.fs_o   = 1'b0;
    d.rx_fs_o = rxfi && fsg_pulse;
    // The first stage feeds only the second one.
    d.s1 = pins_in;
    d.s2 = q.s1;
    d.clk_prev = {q.s2[4], q.s2[2]};
    // Sample-rate divider and frame generator.
    d.srg_cnt = clkg_tick ? 4'h0 : q.srg_cnt + 4'h1;
    d.clkg    = (d.srg_cnt < `SRG_HALF);
    if (!frame_gen_reset_n) d.fsg_cnt = 6'h00;
    else if (clkg_tick)
      d.fsg_cnt = (q.fsg_cnt == `FSG_PER - 6'h01) ? 6'h00 : q.fsg_cnt + 6'h01;
    // Write address and data are accepted in either order.
    if (axi_req.awvalid && !q.aw_ok) begin
      d.aw_ok   = 1'b1;
      d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !q.w_ok) begin
      d.w_ok  = 1'b1;
      d.wdata = axi_req.wdata;
      d.wstrb = axi_req.wstrb;
    end
    if (q.bvalid && axi_req.bready) d.bvalid = 1'b0;
    if (q.rvalid && axi_req.rready) d.rvalid = 1'b0;
    for (int i = 0; i < 4; i++) wm[i*8 +: 8] = {8{q.wstrb[i]}};
    if (wr_fire) begin
      d.aw_ok  = 1'b0;
      d.w_ok   = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = wr_bad ? `RESP_ERR : `RESP_OK;
      case (q.aw_addr)
        `A_CTRL: d.ctrl = 7'((q.ctrl & ~wm) | (q.wdata & wm));
        `A_CFG:  d.cfg  = 14'((q.cfg & ~wm) | (q.wdata & wm));
        `A_TXD: begin
          d.tx_data_reg = (q.tx_data_reg & ~wm) | (q.wdata & wm);
          d.dxr_full = tx_en;
          if (!tx_en && !rx_en) d.lp_cnt = `LOOP_CYC;
        end
        default: d.bresp = d.bresp;
      endcase
    end
    if (rd_fire) begin
      d.rvalid = 1'b1;
      d.rresp  = rd_bad ? `RESP_ERR : `RESP_OK;
      case (axi_req.araddr)
        `A_CTRL: d.rdata = {25'h0, q.ctrl};
        `A_CFG:  d.rdata = {18'h0, q.cfg};
        `A_TXD:  d.rdata = q.tx_data_reg;
        `A_RXD: begin
          d.rdata  = q.rx_data_reg;
          d.rx_rdy = 1'b0;
        end
        `A_STAT: d.rdata = {26'h0, q.rx_st == RX_SHIFT, q.tx_st == TX_SHIFT,
                            fsg_used, srg_used, tx_rdy, q.rx_rdy};
        default: d.rdata = 32'h0;
      endcase
    end
    if (q.lp_cnt != 3'h0) begin
      d.lp_cnt = q.lp_cnt - 3'h1;
      if (q.lp_cnt == `LOOP_CYC) d.lp_code = tx_byte;
      if (q.lp_cnt == 3'h1) d.rx_data_reg = rx_just;
    end
    if (tx_start) begin
      ld = tx_el8 ? {tx_byte, 8'h00} : q.tx_data_reg[15:0];
      d.tx_shift_reg      = ld;
      d.dx       = ld[15];
      d.tx_cnt   = tx_el8 ? 5'h07 : 5'h0F;
      d.tx_st    = TX_SHIFT;
      d.dxr_full = 1'b0;
      d.tx_evt   = 1'b1;
      d.fs_o     = txfi;
    end else if (q.tx_st == TX_SHIFT && tx_tick) begin
      if (q.tx_cnt == 5'h00) begin
        d.tx_st = TX_IDLE;
        d.dx    = 1'b0;
      end else begin
        d.tx_shift_reg    = {q.tx_shift_reg[14:0], 1'b0};
        d.dx     = q.tx_shift_reg[14];
        d.tx_cnt = q.tx_cnt - 5'h01;
      end
    end
    if (wr_fire && q.aw_addr == `A_TXD) d.dxr_full = tx_en;
    // Receive shifter gathers one element after its sync.
    d.rbr_new = 1'b0;
    case (q.rx_st)
      RX_IDLE: if (rx_en && rx_tick && rx_fs) begin
        d.rsr    = 16'h0000;
        d.rx_cnt = rx_el8 ? 5'h08 : 5'h10;
        d.rx_st  = RX_SHIFT;
      end
      RX_SHIFT: if (rx_tick) begin
        d.rsr    = {q.rsr[14:0], rx_din};
        d.rx_cnt = q.rx_cnt - 5'h01;
        if (q.rx_cnt == 5'h01) begin
          d.rx_buffer_reg     = {q.rsr[14:0], rx_din};
          d.rbr_new = 1'b1;
          d.rx_st   = RX_IDLE;
        end
      end
      default: d.rx_st = RX_IDLE;
    endcase
    if (rx_copy) begin
      d.rx_data_reg    = rx_just;
      d.rx_rdy = 1'b1;
      d.rx_evt = 1'b1;
    end
    if (!tx_en) begin
      d.tx_st    = TX_IDLE;
      d.dxr_full = 1'b0;
      d.dx       = 1'b0;
    end
    if (!rx_en) begin
      d.rx_st   = RX_IDLE;
      d.rx_rdy  = 1'b0;
      d.rbr_new = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) q <= '0;
    else q <= d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Clock and sync drivers are enabled only when the matching source is internal; the data driver only while shifting.
  always_comb begin
    pins_out.tx_bit_clock_o   = q.clkg;
    pins_out.tx_bit_clock_oe  = txci;
    pins_out.tx_frame_sync_o  = q.fs_o;
    pins_out.tx_frame_sync_oe = txfi;
    pins_out.rx_bit_clock_o   = q.clkg;
    pins_out.rx_bit_clock_oe  = rxci;
    pins_out.rx_frame_sync_o  = q.rx_fs_o;
    pins_out.rx_frame_sync_oe = rxfi;
    pins_out.tx_data_o        = q.dx;
    pins_out.tx_data_oe       = (q.tx_st == TX_SHIFT);
  end
  assign rx_sync_event = q.rx_evt;
  assign tx_sync_event = q.tx_evt;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_loop_wr;
    wr_fire && (q.aw_addr == `A_TXD) && !tx_en && !rx_en;
  endsequence
  property p_loop_time;
    s_loop_wr |-> ##5 (q.rx_data_reg == $past(rx_just, 2));
  endproperty
  a_loop_time: assert property (p_loop_time) else $error("loop result late");
  property p_loop_flags;
    s_loop_wr |-> (!q.rx_rdy && !tx_rdy) [*5];
  endproperty
  a_loop_flags: assert property (p_loop_flags) else $error("ready set in loop");
  property p_fs_copy;
    tx_start && fs_copy_mode |=> q.fs_o && (q.tx_st == TX_SHIFT);
  endproperty
  a_fs_copy: assert property (p_fs_copy) else $error("no sync on copy");
  property p_fs_gen;
    tx_start && txfi && fmode |-> fsg_pulse;
  endproperty
  a_fs_gen: assert property (p_fs_gen) else $error("sync not from generator");
  property p_rx_srg;
    rx_tick && rxci && !loop_on |-> clkg_tick;
  endproperty
  a_rx_srg: assert property (p_rx_srg) else $error("rx clock not shared");
  property p_comp8;
    tx_start && (tx_law == LAW_MU || tx_law == LAW_A) |=> q.tx_cnt == 5'h07;
  endproperty
  a_comp8: assert property (p_comp8) else $error("compand not 8 bits");
  property p_sat_mu;
    tx_law == LAW_MU && q.tx_data_reg[15:0] == 16'h7FFF |-> tx_byte == 8'h80;
  endproperty
  a_sat_mu: assert property (p_sat_mu) else $error("mu not saturated");
  property p_sat_a;
    tx_law == LAW_A && q.tx_data_reg[15:0] == 16'h8000 |-> tx_byte == 8'h2A;
  endproperty
  a_sat_a: assert property (p_sat_a) else $error("A-law not saturated");
  property p_rx_copy;
    rx_copy |=> q.rx_rdy && (q.rx_data_reg == $past(rx_just));
  endproperty
  a_rx_copy: assert property (p_rx_copy) else $error("expand copy wrong");
  property p_tx_rst;
    !tx_en |=> (q.tx_st == TX_IDLE) && !q.dxr_full;
  endproperty
  a_tx_rst: assert property (p_tx_rst) else $error("tx not held in reset");
  property p_bus_err;
    wr_fire && wr_bad |=> q.bvalid && (q.bresp == `RESP_ERR);
  endproperty
  a_bus_err: assert property (p_bus_err) else $error("unmapped write accepted");
endmodule : sp_compand_port

// *** tb/sp_line_model.sv ***
// Far-side serial line model for the compander bench.
`timescale 1ns/10ps
module sp_line_model (
  input  wire logic               clk,
  output sp_compand_pkg::pin_in_s pins
);
  import sp_compand_pkg::*;
  logic flip_q = 1'b0;
  // An unused data line toggles every cycle, so a stale bit never passes for data.
  always_ff @(posedge clk) begin
    flip_q <= ~flip_q;
  end
  // External clocks and syncs stand still, as no external frame is ever sent.
  assign pins = '{tx_bit_clock_i: 1'b0, tx_frame_sync_i: 1'b0, rx_bit_clock_i: 1'b0,
                  rx_frame_sync_i: 1'b0, rx_data_i: flip_q};
endmodule : sp_line_model

// *** tb/serial_port_companding_unit_tb_top.sv ***
// Register-level bench for the serial port compander.
`timescale 1ns/10ps
module serial_port_companding_unit_tb_top;
  import sp_compand_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  axi_req_s    rq = '{wstrb: 4'hF, default: '0};
  axi_rsp_s    rs;
  pin_in_s     pi;
  pin_out_s    po;
  logic        rxe;
  logic        txe;
  logic [31:0] rd;
  logic [1:0]  rp;
  int          fails = 0;
  int          checks_done = 0;
  int          tx_cnt = 0;
  int          fs_cnt = 0;
  logic [3:0]  oe_seen;
  // Direct path cases: justify code, laws, written word, expected receive word.
  // the first five cases use one law both ways, so they show the quantization.
  logic [1:0]  jv [7] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0};
  logic [3:0]  lw [7] = '{4'hA, 4'hA, 4'hA, 4'hF, 4'hF, 4'hE, 4'hB};
  logic [31:0] dv [7] = '{32'h7FFF, 32'h8000, 32'h7FFF, 32'h8000, 32'hABCD0000, 32'h0, 32'h0};
  logic [31:0] ev [7] = '{32'h7D7C, 32'hFFFF8284, 32'h7D7C0000, 32'hFFFF8200, 32'h8,
                          32'h350, 32'h2CC};
  initial begin
    forever #2 clk = ~clk;
  end
  sp_compand_port sp_compand_port_inst (.clk(clk), .reset_n(reset_n), .axi_req(rq),
    .axi_rsp(rs), .pins_in(pi), .pins_out(po), .rx_sync_event(rxe), .tx_sync_event(txe));
  sp_line_model sp_line_model_inst (.clk(clk), .pins(pi));
  // Driver enables gathered in the order of the source select bits.
  assign oe_seen = {po.rx_frame_sync_oe, po.rx_bit_clock_oe, po.tx_frame_sync_oe,
                    po.tx_bit_clock_oe};
  // Sampled mid-cycle so a one-cycle pulse is seen exactly once.
  always @(negedge clk) begin
    if (txe === 1'b1) begin
      tx_cnt <= tx_cnt + 1;
    end
    if (po.tx_frame_sync_o === 1'b1) begin
      fs_cnt <= fs_cnt + 1;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  // Decisions are taken at the falling edge, where the ready signals are settled.
  task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    logic ar;
    logic hs;
    int   n;
    hs = 1'b0;
    n = 0;
    @(posedge clk);
    rq.awvalid <= we;
    rq.wvalid <= we;
    rq.bready <= we;
    rq.awaddr <= a;
    rq.wdata <= d;
    rq.arvalid <= !we;
    rq.rready <= !we;
    rq.araddr <= a;
    while (!hs) begin
      @(negedge clk);
      n++;
      aw = rs.awready;
      w = rs.wready;
      ar = rs.arready;
      hs = we ? rs.bvalid : rs.rvalid;
      rp = we ? rs.bresp : rs.rresp;
      rd = rs.rdata;
      @(posedge clk);
      if (aw) begin
        rq.awvalid <= 1'b0;
      end
      if (w) begin
        rq.wvalid <= 1'b0;
      end
      if (ar) begin
        rq.arvalid <= 1'b0;
      end
      if (hs) begin
        rq.bready <= 1'b0;
        rq.rready <= 1'b0;
      end
      if (n > 100) begin
        fails++;
        end_of_test();
      end
    end
  endtask : acc
  task automatic wait_rx();
    int n;
    n = 0;
    while (rxe !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 400) begin
        fails++;
        end_of_test();
      end
    end
  endtask : wait_rx
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    acc(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    acc(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    acc(1'b0, 8'h14, 32'h0);
    check({rd[29:0], rp}, 32'h2);
    acc(1'b1, 8'h05, 32'hF);
    check({30'h0, rp}, 32'h2);
    $display("test map done");
    for (int i = 0; i < 7; i++) begin
      acc(1'b1, 8'h04, {28'h0, lw[i]});
      acc(1'b1, 8'h00, {25'h0, jv[i], 5'h0});
      acc(1'b1, 8'h08, dv[i]);
      repeat (4) @(posedge clk);
      acc(1'b0, 8'h0C, 32'h0);
      check(rd, ev[i]);
      acc(1'b0, 8'h10, 32'h0);
      check(rd, 32'h0);
    end
    $display("test direct done");
    // Byte sent reversed but received plain, so the reversal shows in the data.
    acc(1'b1, 8'h04, 32'hC01);
    acc(1'b1, 8'h00, 32'h7);
    acc(1'b1, 8'h08, 32'h0101);
    wait_rx();
    acc(1'b0, 8'h10, 32'h0);
    check(rd & 32'hF, 32'h7);
    acc(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h80);
    acc(1'b0, 8'h10, 32'h0);
    check(rd & 32'h1, 32'h0);
    acc(1'b1, 8'h00, 32'h0);
    acc(1'b1, 8'h04, 32'hC9A);
    acc(1'b1, 8'h00, 32'h7);
    acc(1'b1, 8'h08, 32'h7FFF);
    wait_rx();
    acc(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h7D7C);
    check(tx_cnt, 32'h2);
    check(fs_cnt, 32'h2);
    acc(1'b1, 8'h00, 32'h1);
    acc(1'b0, 8'h10, 32'h0);
    check(rd & 32'h2, 32'h0);
    acc(1'b1, 8'h00, 32'h3);
    acc(1'b0, 8'h10, 32'h0);
    check(rd & 32'h2, 32'h2);
    $display("test loopback done");
    for (int i = 0; i < 16; i++) begin
      if ((i[3] && !i[2]) || (i[1] && !i[0])) begin
        continue;
      end
      acc(1'b1, 8'h00, 32'h0);
      acc(1'b1, 8'h04, {18'h0, i[3:0], 10'h0});
      // external sync cases never see a frame, so no start-up sequence is needed.
      // The frame generator runs so that its use shows in the status word.
      acc(1'b1, 8'h00, 32'h1B);
      acc(1'b0, 8'h10, 32'h0);
      check(rd & 32'hC, {28'h0, i[1] & i[0] | i[3] & i[2], i[0] | i[2], 2'h0});
      check({28'h0, oe_seen}, {28'h0, i[3:0]});
    end
    $display("test sharing done");
    end_of_test();
  end
endmodule : serial_port_companding_unit_tb_top
